// ### include/iscu_pkg.sv
// Overview of operation
// - Live status word readable without side effects.
// - Falling capture latches one-to-zero transitions.
// - Rising capture latches zero-to-one transitions.
// - Captures clear at reset, read, clear-status.
// - Two masks, one per capture, bitwise.
// - Enabled captured change sets summary bit.
// - All masks zero keeps summary zero.
// - Both masks load zero at power-up.
// - Shared sixteen-bit layout, unused bits zero.
// - Bit 12: output or thermocouple settled.
// - Bit 11: under remote control.
// - Bit 9: target port buffer full.
// - Bit 8: target port data available.
// - Bit 7: programmed voltage above 33 V.
// - Bit 6 zero live, set in captures.
package iscu_pkg;

	localparam int unsigned ISCU_WIDTH = 16;

	localparam int unsigned BIT_OUTPUT_ACTIVE     = 0;
	localparam int unsigned BIT_AUX_AMP_VOLTAGE   = 2;
	localparam int unsigned BIT_AUX_AMP_CURRENT   = 3;
	localparam int unsigned BIT_TEMP_CALIBRATION  = 5;
	localparam int unsigned BIT_MAGNITUDE_CHANGE  = 6;
	localparam int unsigned BIT_HIGH_VOLTAGE      = 7;
	localparam int unsigned BIT_TARGET_DATA_READY = 8;
	localparam int unsigned BIT_TARGET_BUF_FULL   = 9;
	localparam int unsigned BIT_REMOTE_CONTROL    = 11;
	localparam int unsigned BIT_OUTPUT_SETTLED    = 12;
	localparam int unsigned BIT_REPORT_PRINTING   = 13;

	localparam logic [15:0] ISCU_USED_MASK     = 16'h3BED;
	localparam logic [15:0] ISCU_LIVE_MASK     = 16'h3BAD;
	localparam logic [15:0] ISCU_CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] ISCU_MASK_RESET    = 16'h0000;

	localparam int unsigned ISCU_VOLT_W        = 20;
	localparam logic [19:0] ISCU_HIGH_VOLT_MV  = 20'h080E8;
	localparam logic [2:0]  ISCU_ARM_CYCLES    = 3'h6;

	typedef enum logic [2:0] {
		CMD_READ_LIVE      = 3'b000,
		CMD_READ_FALL_CAP  = 3'b001,
		CMD_READ_RISE_CAP  = 3'b010,
		CMD_READ_FALL_MASK = 3'b011,
		CMD_READ_RISE_MASK = 3'b100,
		CMD_WRITE_FALL_MSK = 3'b101,
		CMD_WRITE_RISE_MSK = 3'b110,
		CMD_CLEAR_STATUS   = 3'b111
	} iscu_cmd_t;

endpackage

// ### tb/iscu_ctrl_model.sv
`timescale 1ns/10ps
module iscu_ctrl_model
	import iscu_pkg::*;
(
	input  wire logic                            sys_clk,
	input  wire logic                            rsp_valid,
	input  wire logic [iscu_pkg::ISCU_WIDTH-1:0] rsp_data,
	output logic                                 cmd_valid,
	output iscu_pkg::iscu_cmd_t                  cmd_code,
	output logic      [iscu_pkg::ISCU_WIDTH-1:0] cmd_wdata
);
	import iscu_pkg::*;

	initial begin
		cmd_valid = 1'b0;
		cmd_code = CMD_READ_LIVE;
		cmd_wdata = 16'h0000;
	end

	// One strobe cycle per request; the data word is inverted once released so stale data is
	// never mistaken for a fresh write.
	task automatic issue(input iscu_cmd_t code, input logic [15:0] data);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_wdata <= data;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_wdata <= ~data;
	endtask

	task automatic query(input iscu_cmd_t code, output logic [15:0] data, output logic got);
		issue(code, cmd_wdata);
		@(posedge sys_clk);
		got = rsp_valid;
		data = rsp_data;
	endtask
endmodule // iscu_ctrl_model

// ### tb/iscu_top_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module iscu_top_tb;
	import iscu_pkg::*;
	localparam int LIMIT = 4000;
	logic        sys_clk, reset_n, report_printing, output_settled, tc_settled;
	logic        remote_control, target_port_buffer_full, target_port_data_ready;
	logic        temporary_calibration_in_use, aux_amp_current, aux_amp_voltage;
	logic        output_active, magnitude_side_change, cmd_valid, rsp_valid;
	logic        status_change_summary;
	logic [19:0] programmed_millivolts;
	logic [15:0] cmd_wdata, rsp_data;
	iscu_cmd_t   cmd_code;
	logic [15:0] bits [11];
	int          n_mismatch = 0;
	int          checked = 0;
	int          cycles = 0;

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	iscu_top i_iscu_top (
		.sys_clk(sys_clk), .reset_n(reset_n), .report_printing(report_printing),
		.output_settled(output_settled), .tc_settled(tc_settled),
		.remote_control(remote_control), .target_port_buffer_full(target_port_buffer_full),
		.target_port_data_ready(target_port_data_ready),
		.programmed_millivolts(programmed_millivolts),
		.temporary_calibration_in_use(temporary_calibration_in_use),
		.aux_amp_current(aux_amp_current), .aux_amp_voltage(aux_amp_voltage),
		.output_active(output_active), .magnitude_side_change(magnitude_side_change),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.status_change_summary(status_change_summary)
	);

	iscu_ctrl_model i_iscu_ctrl_model (
		.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata)
	);

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_mismatch++;
			end_sim();
		end
	end

	// Pins pass two sync flops plus the compare stage, so eight cycles covers capture and summary.
	task automatic set_pins(input logic [15:0] w, input logic tc);
		@(posedge sys_clk);
		report_printing <= w[13];
		output_settled <= w[12] & ~tc;
		tc_settled <= w[12] & tc;
		remote_control <= w[11];
		target_port_buffer_full <= w[9];
		target_port_data_ready <= w[8];
		programmed_millivolts <= w[7] ? 20'h080E9 : 20'h080E8;
		temporary_calibration_in_use <= w[5];
		aux_amp_current <= w[3];
		aux_amp_voltage <= w[2];
		output_active <= w[0];
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic rd(input iscu_cmd_t code, input logic [15:0] exp);
		logic [15:0] d;
		logic        g;
		i_iscu_ctrl_model.query(code, d, g);
		`CHK(g, 1'b1)
		`CHK(d, exp)
	endtask

	task automatic wr(input iscu_cmd_t code, input logic [15:0] data);
		i_iscu_ctrl_model.issue(code, data);
		repeat (2) @(posedge sys_clk);
	endtask

	initial begin
		bits = '{16'h0001, 16'h0004, 16'h0008, 16'h0020, 16'h0080, 16'h0100,
			16'h0200, 16'h0800, 16'h1000, 16'h2000, 16'h1000};
		reset_n = 1'b0;
		magnitude_side_change = 1'b0;
		{report_printing, output_settled, tc_settled, remote_control} = 4'h0;
		{target_port_buffer_full, target_port_data_ready, output_active} = 3'h0;
		{temporary_calibration_in_use, aux_amp_current, aux_amp_voltage} = 3'h0;
		programmed_millivolts = 20'h080E8;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		rd(CMD_READ_LIVE, 16'h0000);
		rd(CMD_READ_FALL_CAP, 16'h0000);
		rd(CMD_READ_RISE_CAP, 16'h0000);
		rd(CMD_READ_FALL_MASK, 16'h0000);
		rd(CMD_READ_RISE_MASK, 16'h0000);
		wr(CMD_WRITE_FALL_MSK, 16'hFFFF);
		rd(CMD_READ_FALL_MASK, 16'h3BED);
		wr(CMD_WRITE_RISE_MSK, 16'hC412);
		rd(CMD_READ_RISE_MASK, 16'h0000);
		wr(CMD_WRITE_FALL_MSK, 16'h0000);
		// The last entry drives the settled bit from the thermocouple pin instead.
		for (int i = 0; i < 11; i++) begin
			set_pins(bits[i], i == 10);
			rd(CMD_READ_LIVE, bits[i]);
			`CHK(status_change_summary, 1'b0)
		end
		rd(CMD_READ_LIVE, 16'h1000);
		rd(CMD_READ_FALL_CAP, 16'h3BAD);
		rd(CMD_READ_RISE_CAP, 16'h3BAD);
		rd(CMD_READ_FALL_CAP, 16'h0000);
		rd(CMD_READ_RISE_CAP, 16'h0000);
		set_pins(16'h0000, 1'b0);
		`CHK(status_change_summary, 1'b0)
		rd(CMD_READ_FALL_CAP, 16'h1000);
		wr(CMD_WRITE_RISE_MSK, 16'h1000);
		set_pins(16'h0800, 1'b0);
		`CHK(status_change_summary, 1'b0)
		set_pins(16'h1800, 1'b1);
		`CHK(status_change_summary, 1'b1)
		rd(CMD_READ_RISE_CAP, 16'h1800);
		repeat (2) @(posedge sys_clk);
		`CHK(status_change_summary, 1'b0)
		wr(CMD_WRITE_FALL_MSK, 16'h0001);
		set_pins(16'h1801, 1'b0);
		set_pins(16'h1800, 1'b0);
		`CHK(status_change_summary, 1'b1)
		wr(CMD_CLEAR_STATUS, 16'h0000);
		`CHK(status_change_summary, 1'b0)
		rd(CMD_READ_FALL_CAP, 16'h0000);
		rd(CMD_READ_RISE_CAP, 16'h0000);
		rd(CMD_READ_FALL_MASK, 16'h0001);
		@(posedge sys_clk);
		magnitude_side_change <= 1'b1;
		@(posedge sys_clk);
		magnitude_side_change <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rd(CMD_READ_LIVE, 16'h1800);
		rd(CMD_READ_FALL_CAP, 16'h0040);
		rd(CMD_READ_RISE_CAP, 16'h0040);
		// A mid-run reset with conditions already true must leave masks and captures zero.
		set_pins(16'h1880, 1'b0);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rd(CMD_READ_LIVE, 16'h1880);
		rd(CMD_READ_FALL_MASK, 16'h0000);
		rd(CMD_READ_RISE_MASK, 16'h0000);
		rd(CMD_READ_FALL_CAP, 16'h0000);
		rd(CMD_READ_RISE_CAP, 16'h0000);
		`CHK(status_change_summary, 1'b0)
		end_sim();
	end
endmodule // iscu_top_tb

// ### verilog/iscu_capture.sv
`timescale 1ns/10ps
module iscu_capture #(
	parameter int unsigned         WIDTH     = 16,
	parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] value
);
	logic [WIDTH-1:0] cap_q;

	// A transition seen in the clearing cycle survives the clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_q <= RESET_VAL;
		end else begin
			cap_q <= (cap_q & ~{WIDTH{clear}}) | set_bits;
		end
	end

	assign value = cap_q;

	cap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!clear |=> ((cap_q & $past(cap_q)) == $past(cap_q)))
		else $error("Capture lost a bit without a clear.");

	cap_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> (cap_q == $past(set_bits)))
		else $error("Capture not cleared to the new transitions.");
endmodule // iscu_capture

// ### verilog/iscu_sync.sv
`timescale 1ns/10ps
module iscu_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// Each bit has its own pair; only the second stage is ever read.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q[i]   <= 1'b0;
				stable_q[i] <= 1'b0;
			end else begin
				meta_q[i]   <= async_in[i];
				stable_q[i] <= meta_q[i];
			end
		end
	end

	assign sync_out = stable_q;
endmodule // iscu_sync

// ### verilog/iscu_top.sv
`timescale 1ns/10ps
module iscu_top
	import iscu_pkg::*;
#(
	parameter int unsigned            VOLT_W       = iscu_pkg::ISCU_VOLT_W,
	parameter logic [VOLT_W-1:0]      HIGH_VOLT_MV = iscu_pkg::ISCU_HIGH_VOLT_MV
) (
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	input  wire logic                        report_printing,
	input  wire logic                        output_settled,
	input  wire logic                        tc_settled,
	input  wire logic                        remote_control,
	input  wire logic                        target_port_buffer_full,
	input  wire logic                        target_port_data_ready,
	input  wire logic [VOLT_W-1:0]           programmed_millivolts,
	input  wire logic                        temporary_calibration_in_use,
	input  wire logic                        aux_amp_current,
	input  wire logic                        aux_amp_voltage,
	input  wire logic                        output_active,
	input  wire logic                        magnitude_side_change,
	input  wire logic                        cmd_valid,
	input  wire iscu_pkg::iscu_cmd_t         cmd_code,
	input  wire logic [iscu_pkg::ISCU_WIDTH-1:0] cmd_wdata,
	output logic                             rsp_valid,
	output logic      [iscu_pkg::ISCU_WIDTH-1:0] rsp_data,
	output logic                             status_change_summary
);
	import iscu_pkg::*;

	localparam int unsigned PIN_W = 10;

	logic                  rst_meta_q;
	logic                  rst_n_q;
	logic [PIN_W-1:0]      pins_raw;
	logic [PIN_W-1:0]      pins_s;
	logic [VOLT_W-1:0]     volt_s;
	logic [VOLT_W-1:0]     volt_prev_q;
	logic [VOLT_W-1:0]     volt_ok_q;
	logic [ISCU_WIDTH-1:0] live_d;
	logic [ISCU_WIDTH-1:0] live_q;
	logic [ISCU_WIDTH-1:0] prev_q;
	logic [2:0]            arm_cnt_q;
	logic                  armed;
	logic [ISCU_WIDTH-1:0] magnitude_bit;
	logic [ISCU_WIDTH-1:0] fall_set;
	logic [ISCU_WIDTH-1:0] rise_set;
	logic [ISCU_WIDTH-1:0] fall_cap;
	logic [ISCU_WIDTH-1:0] rise_cap;
	logic [ISCU_WIDTH-1:0] fall_mask_q;
	logic [ISCU_WIDTH-1:0] rise_mask_q;
	logic                  do_read;
	logic                  clear_status;
	logic                  clear_fall;
	logic                  clear_rise;
	logic [ISCU_WIDTH-1:0] read_mux;
	logic                  any_enabled;
	logic                  rsp_valid_q;
	logic [ISCU_WIDTH-1:0] rsp_data_q;
	logic                  summary_q;

	// Reset is taken asynchronously and released through two flops.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	assign pins_raw = {report_printing, output_settled, tc_settled, remote_control,
		target_port_buffer_full, target_port_data_ready, temporary_calibration_in_use,
		aux_amp_current, aux_amp_voltage, output_active};

	iscu_sync #(
		.WIDTH    (PIN_W)
	) u_pin_sync (
		.clk      (sys_clk),
		.rst_n    (rst_n_q),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	iscu_sync #(
		.WIDTH    (VOLT_W)
	) u_volt_sync (
		.clk      (sys_clk),
		.rst_n    (rst_n_q),
		.async_in (programmed_millivolts),
		.sync_out (volt_s)
	);

	// Bits of a changing word may resolve one cycle apart, so a word is taken
	// only once two samples agree; this costs two cycles on the voltage path.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			volt_prev_q <= '0;
			volt_ok_q   <= '0;
		end else begin
			volt_prev_q <= volt_s;
			if (volt_s == volt_prev_q) begin
				volt_ok_q <= volt_s;
			end
		end
	end

	// Assemble the live word in the shared bit layout.
	always_comb begin
		live_d                        = '0;
		live_d[BIT_REPORT_PRINTING]   = pins_s[9];
		live_d[BIT_OUTPUT_SETTLED]    = pins_s[8] | pins_s[7];
		live_d[BIT_REMOTE_CONTROL]    = pins_s[6];
		live_d[BIT_TARGET_BUF_FULL]   = pins_s[5];
		live_d[BIT_TARGET_DATA_READY] = pins_s[4];
		live_d[BIT_HIGH_VOLTAGE]      = (volt_ok_q > HIGH_VOLT_MV);
		live_d[BIT_MAGNITUDE_CHANGE]  = 1'b0;
		live_d[BIT_TEMP_CALIBRATION]  = pins_s[3];
		live_d[BIT_AUX_AMP_CURRENT]   = pins_s[2];
		live_d[BIT_AUX_AMP_VOLTAGE]   = pins_s[1];
		live_d[BIT_OUTPUT_ACTIVE]     = pins_s[0];
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			live_q <= '0;
			prev_q <= '0;
		end else begin
			live_q <= live_d & ISCU_LIVE_MASK;
			prev_q <= live_q;
		end
	end

	// Detection waits until the pipeline holds real pin values, so that
	// conditions already true at power-on are not reported as changes.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			arm_cnt_q <= 3'h0;
		end else if (arm_cnt_q != ISCU_ARM_CYCLES) begin
			arm_cnt_q <= arm_cnt_q + 3'h1;
		end
	end

	assign armed = (arm_cnt_q == ISCU_ARM_CYCLES);

	always_comb begin
		magnitude_bit                       = '0;
		magnitude_bit[BIT_MAGNITUDE_CHANGE] = magnitude_side_change;
	end

	assign fall_set = ({ISCU_WIDTH{armed}} & prev_q & ~live_q) | magnitude_bit;
	assign rise_set = ({ISCU_WIDTH{armed}} & ~prev_q & live_q) | magnitude_bit;

	assign do_read      = cmd_valid && (cmd_code != CMD_WRITE_FALL_MSK)
		&& (cmd_code != CMD_WRITE_RISE_MSK) && (cmd_code != CMD_CLEAR_STATUS);
	assign clear_status = cmd_valid && (cmd_code == CMD_CLEAR_STATUS);
	assign clear_fall   = clear_status || (cmd_valid && cmd_code == CMD_READ_FALL_CAP);
	assign clear_rise   = clear_status || (cmd_valid && cmd_code == CMD_READ_RISE_CAP);

	iscu_capture #(
		.WIDTH     (ISCU_WIDTH),
		.RESET_VAL (ISCU_CAPTURE_RESET)
	) u_fall_cap (
		.clk       (sys_clk),
		.rst_n     (rst_n_q),
		.set_bits  (fall_set),
		.clear     (clear_fall),
		.value     (fall_cap)
	);

	iscu_capture #(
		.WIDTH     (ISCU_WIDTH),
		.RESET_VAL (ISCU_CAPTURE_RESET)
	) u_rise_cap (
		.clk       (sys_clk),
		.rst_n     (rst_n_q),
		.set_bits  (rise_set),
		.clear     (clear_rise),
		.value     (rise_cap)
	);

	// Masks survive clear-status; only reset or a mask write changes them.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fall_mask_q <= ISCU_MASK_RESET;
		end else if (cmd_valid && cmd_code == CMD_WRITE_FALL_MSK) begin
			fall_mask_q <= cmd_wdata & ISCU_USED_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rise_mask_q <= ISCU_MASK_RESET;
		end else if (cmd_valid && cmd_code == CMD_WRITE_RISE_MSK) begin
			rise_mask_q <= cmd_wdata & ISCU_USED_MASK;
		end
	end

	always_comb begin
		case (cmd_code)
			CMD_READ_LIVE:      read_mux = live_q;
			CMD_READ_FALL_CAP:  read_mux = fall_cap;
			CMD_READ_RISE_CAP:  read_mux = rise_cap;
			CMD_READ_FALL_MASK: read_mux = fall_mask_q;
			CMD_READ_RISE_MASK: read_mux = rise_mask_q;
			default:            read_mux = '0;
		endcase
	end

	// Each query answers one cycle later with the value before any clear.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= '0;
		end else begin
			rsp_valid_q <= do_read;
			if (do_read) begin
				rsp_data_q <= read_mux & ISCU_USED_MASK;
			end
		end
	end

	assign any_enabled = |((fall_cap & fall_mask_q) | (rise_cap & rise_mask_q));

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			summary_q <= 1'b0;
		end else begin
			summary_q <= any_enabled;
		end
	end

	assign rsp_valid             = rsp_valid_q;
	assign rsp_data              = rsp_data_q;
	assign status_change_summary = summary_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n_q);

	live_read_a: assert property (
		(cmd_valid && cmd_code == CMD_READ_LIVE) |=> rsp_valid && rsp_data == $past(live_q))
		else $error("Live read returned a wrong word.");

	live_read_pure_a: assert property (
		(cmd_valid && cmd_code == CMD_READ_LIVE) |=> ((fall_cap & $past(fall_cap))
			== $past(fall_cap)) && ((rise_cap & $past(rise_cap)) == $past(rise_cap)))
		else $error("Live read disturbed a capture register.");

	fall_edge_a: assert property (
		(armed && |(prev_q & ~live_q)) |=> ((fall_cap & $past(prev_q & ~live_q))
			== $past(prev_q & ~live_q)))
		else $error("Falling transition not captured.");

	rise_edge_a: assert property (
		(armed && |(live_q & ~prev_q)) |=> ((rise_cap & $past(live_q & ~prev_q))
			== $past(live_q & ~prev_q)))
		else $error("Rising transition not captured.");

	cls_clear_a: assert property (
		(clear_status && fall_set == '0 && rise_set == '0) |=> fall_cap == '0 && rise_cap == '0)
		else $error("Clear status left a capture bit set.");

	read_clear_a: assert property (
		(cmd_valid && cmd_code == CMD_READ_RISE_CAP) |=> rsp_data == ($past(rise_cap)
			& ISCU_USED_MASK) && rise_cap == $past(rise_set))
		else $error("Rising capture read did not return and clear.");

	mask_write_a: assert property (
		(cmd_valid && cmd_code == CMD_WRITE_FALL_MSK) |=> fall_mask_q == ($past(cmd_wdata)
			& ISCU_USED_MASK))
		else $error("Falling mask write not stored.");

	mask_reset_a: assert property (
		$rose(rst_n_q) |-> fall_mask_q == ISCU_MASK_RESET && rise_mask_q == ISCU_MASK_RESET)
		else $error("Masks not zero after reset.");

	summary_set_a: assert property (
		any_enabled |=> status_change_summary)
		else $error("Enabled change did not raise the summary.");

	summary_off_a: assert property (
		(fall_mask_q == '0 && rise_mask_q == '0)[*2] |-> !status_change_summary)
		else $error("Summary raised with all masks zero.");

	summary_eq_a: assert property (
		##1 status_change_summary == $past(any_enabled))
		else $error("Summary does not follow the masked captures.");

	reserved_zero_a: assert property (
		(rsp_data & ~ISCU_USED_MASK) == '0 && (live_q & ~ISCU_LIVE_MASK) == '0)
		else $error("Reserved bit reads as one.");

	magnitude_cap_a: assert property (
		magnitude_side_change |=> fall_cap[BIT_MAGNITUDE_CHANGE]
			&& rise_cap[BIT_MAGNITUDE_CHANGE] && !live_q[BIT_MAGNITUDE_CHANGE])
		else $error("Magnitude change not captured in both registers.");

	settled_bit_a: assert property (
		##1 live_q[BIT_OUTPUT_SETTLED] == $past(pins_s[8] | pins_s[7]))
		else $error("Settled bit does not follow its sources.");

	high_volt_a: assert property (
		##1 live_q[BIT_HIGH_VOLTAGE] == $past(volt_ok_q > HIGH_VOLT_MV))
		else $error("High voltage bit wrong for the programmed value.");

	remote_bit_a: assert property (
		##1 live_q[BIT_REMOTE_CONTROL] == $past(pins_s[6]))
		else $error("Remote bit does not follow remote control.");
endmodule // iscu_top
